// *** rtl/swhr_pkg.sv ***
// What this block does
// - Current SEU frame register shows region [20:16], column [15:8], frame [7:0].
// - Next SEU frame register uses the same fields; bits [31:21] read zero.
// - Warmboot control bit 0 enables version fallback; resets to 0.
// - Warmboot flash start address low 24 bits hold a byte address, reset zero.
// - Top eight address bits apply only in four-byte flash mode; reset zero.
// - History bits 6..3 flag current-attempt failures; bit 0 marks record valid.
// - History bits 14..11 flag previous-attempt failures; bit 8 marks it valid.
// - History bit 2 and bit 10 mark current and previous upgrade images.
// - History bit 1 and bit 9 mark fallback attempts; bit 7, [31:15] zero.
// - SEU status reports single-bit error position within the current frame.
//
// Purpose: constants and carrier types for the SEU / warmboot / history bank
// Assumes: register writes arrive already decoded from type 1 packets
// Notes:   register index is the 5-bit field [26:22] of the packet header
package swhr_pkg;

	localparam int unsigned SWHR_AW       = 5;
	localparam int unsigned SWHR_DW       = 32;
	localparam int unsigned SEU_IDX_W     = 12;

	// Register indices
	localparam logic [SWHR_AW-1:0] IDX_WB_CTRL   = 5'h0f;
	localparam logic [SWHR_AW-1:0] IDX_WB_FLASH  = 5'h10;
	localparam logic [SWHR_AW-1:0] IDX_SEU_STAT  = 5'h1b;
	localparam logic [SWHR_AW-1:0] IDX_SEU_CUR   = 5'h1c;
	localparam logic [SWHR_AW-1:0] IDX_SEU_NEXT  = 5'h1d;
	localparam logic [SWHR_AW-1:0] IDX_HISTORY   = 5'h1e;

	// Field positions
	localparam int unsigned WB_VBACK_BIT  = 0;
	localparam int unsigned FLASH_LOW_W   = 24;
	localparam int unsigned FLASH_HIGH_W  = 8;
	localparam int unsigned SEU_IDX_LSB   = 3;
	localparam int unsigned SEU_SEC_BIT   = 1;
	localparam int unsigned FRAME_PAD_W   = 11;
	localparam int unsigned HIST_PAD_W    = 17;

	// Reset values
	localparam logic                 WB_VBACK_RST  = 1'b0;
	localparam logic [SWHR_DW-1:0]   WB_FLASH_RST  = 32'h0000_0000;
	localparam logic [SWHR_DW-1:0]   RDATA_RST     = 32'h0000_0000;
	localparam logic                 HIST_RSVD     = 1'b0;

	typedef struct packed {
		logic [4:0] region;
		logic [7:0] column;
		logic [7:0] frame;
	} swhr_frame_type;

	// Order matches history bits 6..0 and 14..8
	typedef struct packed {
		logic watchdog_expired;
		logic readback_check_fail;
		logic check_fail;
		logic identity_mismatch;
		logic upgrade_image;
		logic fell_back;
		logic record_valid;
	} swhr_attempt_type;

	localparam swhr_attempt_type ATTEMPT_CLR = 7'h00;

endpackage : swhr_pkg

// *** rtl/swhr_regs.sv ***
// Purpose: SEU frame address, warmboot and boot history register bank
// Assumes: all inputs except rst_b_i come from logic on sys_clk_i
// Notes:   reads answer one cycle later; writes to read-only indices are dropped
`timescale 1ns/1ns
module swhr_regs
	import swhr_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_b_i,
	// Decoded configuration packet access
	input  wire logic                 cfg_wr_i,
	input  wire logic                 cfg_rd_i,
	input  wire logic [SWHR_AW-1:0]   cfg_addr_i,
	input  wire logic [SWHR_DW-1:0]   cfg_wdata_i,
	output logic      [SWHR_DW-1:0]   cfg_rdata_o,
	output logic                      cfg_rvalid_o,
	// SEU scan engine
	input  wire swhr_frame_type       seu_cur_i,
	input  wire swhr_frame_type       seu_next_i,
	input  wire logic                 seu_single_err_i,
	input  wire logic [SEU_IDX_W-1:0] seu_bit_index_i,
	// Boot attempt events
	input  wire logic                 attempt_start_i,
	input  wire swhr_attempt_type     attempt_event_i,
	// Flash loader
	input  wire logic                 four_byte_mode_i,
	output logic                      vback_en_o,
	output logic      [SWHR_DW-1:0]   flash_start_o
);

	typedef struct packed {
		logic                 vback_en;
		logic [SWHR_DW-1:0]   flash_start;
		logic [SWHR_DW-1:0]   flash_out;
		swhr_frame_type       seu_cur;
		swhr_frame_type       seu_next;
		logic [SEU_IDX_W-1:0] seu_idx;
		logic                 seu_sec;
		swhr_attempt_type     now;
		swhr_attempt_type     prior;
		logic [SWHR_DW-1:0]   rdata;
		logic                 rvalid;
	} swhr_state_type;

	swhr_state_type st_q;
	swhr_state_type st_d;
	logic [1:0]     rst_sync_q;
	logic           rst_n;

	function automatic logic [SWHR_DW-1:0] frame_word(input swhr_frame_type f);
		frame_word = {{FRAME_PAD_W{1'b0}}, f};
	endfunction

	function automatic logic [SWHR_DW-1:0] history_word(input swhr_attempt_type cur,
		input swhr_attempt_type prev);
		history_word = {{HIST_PAD_W{1'b0}}, prev, HIST_RSVD, cur};
	endfunction

	function automatic logic [SWHR_DW-1:0] seu_status_word(input logic [SEU_IDX_W-1:0] idx,
		input logic sec);
		logic [SWHR_DW-1:0] w;
		w = '0;
		w[SEU_IDX_LSB +: SEU_IDX_W] = idx;
		w[SEU_SEC_BIT] = sec;
		seu_status_word = w;
	endfunction

	// Reset release through two flops
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_comb begin
		st_d = st_q;
		st_d.rvalid = cfg_rd_i;
		// Scan position follows the engine every cycle
		st_d.seu_cur  = seu_cur_i;
		st_d.seu_next = seu_next_i;
		if (seu_single_err_i) begin
			st_d.seu_idx = seu_bit_index_i;
			st_d.seu_sec = 1'b1;
		end
		if (cfg_wr_i) begin
			case (cfg_addr_i)
				IDX_WB_CTRL: begin
					st_d.vback_en = cfg_wdata_i[WB_VBACK_BIT];
				end
				IDX_WB_FLASH: begin
					st_d.flash_start = cfg_wdata_i;
				end
				default: begin
					st_d.vback_en = st_q.vback_en;
				end
			endcase
		end
		// Upper byte only reaches the loader in four-byte mode
		if (four_byte_mode_i) begin
			st_d.flash_out = st_d.flash_start;
		end else begin
			st_d.flash_out = {{FLASH_HIGH_W{1'b0}}, st_d.flash_start[FLASH_LOW_W-1:0]};
		end
		// Roll history, then record; events in the start cycle are kept
		if (attempt_start_i) begin
			st_d.prior = st_q.now;
			st_d.now   = ATTEMPT_CLR;
		end
		st_d.now = st_d.now | attempt_event_i;
		st_d.rdata = RDATA_RST;
		if (cfg_rd_i) begin
			case (cfg_addr_i)
				IDX_WB_CTRL: begin
					st_d.rdata[WB_VBACK_BIT] = st_q.vback_en;
				end
				IDX_WB_FLASH: begin
					st_d.rdata = st_q.flash_start;
				end
				IDX_SEU_STAT: begin
					st_d.rdata = seu_status_word(st_q.seu_idx, st_q.seu_sec);
				end
				IDX_SEU_CUR: begin
					st_d.rdata = frame_word(st_q.seu_cur);
				end
				IDX_SEU_NEXT: begin
					st_d.rdata = frame_word(st_q.seu_next);
				end
				IDX_HISTORY: begin
					st_d.rdata = history_word(st_q.now, st_q.prior);
				end
				default: begin
					st_d.rdata = RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.vback_en    <= WB_VBACK_RST;
			st_q.flash_start <= WB_FLASH_RST;
			st_q.flash_out   <= WB_FLASH_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg_rdata_o   = st_q.rdata;
	assign cfg_rvalid_o  = st_q.rvalid;
	assign vback_en_o    = st_q.vback_en;
	assign flash_start_o = st_q.flash_out;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	wb_ctrl_write_a: assert property (
		cfg_wr_i && cfg_addr_i == IDX_WB_CTRL
		|=> vback_en_o == $past(cfg_wdata_i[WB_VBACK_BIT]))
		else $error("fallback enable did not take the written bit");

	flash_low_write_a: assert property (
		cfg_wr_i && cfg_addr_i == IDX_WB_FLASH
		|=> flash_start_o[FLASH_LOW_W-1:0] == $past(cfg_wdata_i[FLASH_LOW_W-1:0]))
		else $error("flash start low bits not stored");

	flash_high_mode_a: assert property (
		$past(four_byte_mode_i) == 1'b0 |-> flash_start_o[SWHR_DW-1:FLASH_LOW_W] == '0)
		else $error("upper flash byte leaked outside four-byte mode");

	hist_roll_a: assert property (
		attempt_start_i |=> st_q.prior == $past(st_q.now))
		else $error("previous history not copied from current");

	hist_clear_a: assert property (
		attempt_start_i && attempt_event_i == ATTEMPT_CLR |=> st_q.now == ATTEMPT_CLR)
		else $error("current history not cleared on new attempt");

	hist_event_a: assert property (
		attempt_event_i.watchdog_expired ##1 !attempt_start_i [*2]
		|-> st_q.now.watchdog_expired)
		else $error("watchdog failure not held in current history");

	prior_valid_a: assert property (
		attempt_start_i && st_q.now.record_valid |=> st_q.prior.record_valid)
		else $error("previous record valid lost on roll");

	upgrade_flag_a: assert property (
		attempt_event_i.upgrade_image |=> cfg_rd_i && cfg_addr_i == IDX_HISTORY
		|=> cfg_rdata_o[2])
		else $error("upgrade image flag missing from history read");

	hist_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_HISTORY
		|=> cfg_rvalid_o && cfg_rdata_o[7] == 1'b0 && cfg_rdata_o[SWHR_DW-1:15] == '0)
		else $error("history reserved bits not zero");

	seu_cur_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_SEU_CUR
		|=> cfg_rdata_o == frame_word($past(st_q.seu_cur)))
		else $error("current frame read does not match scan position");

	seu_next_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_SEU_NEXT ##1 1'b1
		|-> cfg_rdata_o[SWHR_DW-1:21] == '0 && cfg_rdata_o[20:0] == $past(seu_next_i, 2))
		else $error("next frame read wrong");

	seu_index_a: assert property (
		seu_single_err_i |=> st_q.seu_idx == $past(seu_bit_index_i) && st_q.seu_sec)
		else $error("single-bit error position not captured");

	seu_cur_track_a: assert property (
		rst_n
		|=> st_q.seu_cur == $past(seu_cur_i))
		else $error("current frame not taken from scan engine");

	seu_cur_pad_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_SEU_CUR
		|=> cfg_rdata_o[SWHR_DW-1:SWHR_DW-FRAME_PAD_W] == '0)
		else $error("current frame reserved bits not zero");

	seu_next_track_a: assert property (
		rst_n
		|=> st_q.seu_next == $past(seu_next_i))
		else $error("next frame not taken from scan engine");

	wb_ctrl_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_WB_CTRL
		|=> cfg_rdata_o[SWHR_DW-1:WB_VBACK_BIT+1] == '0 && cfg_rdata_o[WB_VBACK_BIT] == $past(vback_en_o))
		else $error("fallback control read wrong");

	vback_hold_a: assert property (
		!(cfg_wr_i && cfg_addr_i == IDX_WB_CTRL)
		|=> vback_en_o == $past(vback_en_o))
		else $error("fallback enable changed without a write");

	flash_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_WB_FLASH
		|=> cfg_rdata_o == $past(st_q.flash_start))
		else $error("flash start read does not match stored value");

	flash_hold_a: assert property (
		!(cfg_wr_i && cfg_addr_i == IDX_WB_FLASH)
		|=> st_q.flash_start == $past(st_q.flash_start))
		else $error("flash start changed without a write");

	flash_high_full_a: assert property (
		$past(four_byte_mode_i)
		|-> flash_start_o == st_q.flash_start)
		else $error("upper flash byte missing in four-byte mode");

	now_record_a: assert property (
		!attempt_start_i
		|=> st_q.now == ($past(st_q.now) | $past(attempt_event_i)))
		else $error("current history did not gather events");

	now_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_HISTORY
		|=> cfg_rdata_o[6:0] == $past(st_q.now))
		else $error("current history read wrong");

	prior_hold_a: assert property (
		!attempt_start_i
		|=> st_q.prior == $past(st_q.prior))
		else $error("previous history changed without a new attempt");

	prior_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_HISTORY
		|=> cfg_rdata_o[14:8] == $past(st_q.prior))
		else $error("previous history read wrong");

	upgrade_prior_a: assert property (
		attempt_start_i && st_q.now.upgrade_image
		|=> st_q.prior.upgrade_image)
		else $error("upgrade image flag lost on roll");

	fell_back_prior_a: assert property (
		attempt_start_i && st_q.now.fell_back
		|=> st_q.prior.fell_back)
		else $error("fallback flag lost on roll");

	start_event_a: assert property (
		attempt_start_i
		|=> st_q.now == $past(attempt_event_i))
		else $error("new attempt did not start from a clear record");

	seu_sec_sticky_a: assert property (
		st_q.seu_sec
		|=> st_q.seu_sec)
		else $error("single-bit error flag dropped");

	seu_idx_hold_a: assert property (
		!seu_single_err_i
		|=> st_q.seu_idx == $past(st_q.seu_idx))
		else $error("error position changed without an error");

	seu_stat_read_a: assert property (
		cfg_rd_i && cfg_addr_i == IDX_SEU_STAT
		|=> cfg_rdata_o[SEU_IDX_LSB +: SEU_IDX_W] == $past(st_q.seu_idx)
			&& cfg_rdata_o[SEU_SEC_BIT] == $past(st_q.seu_sec)
			&& cfg_rdata_o[SWHR_DW-1:SEU_IDX_LSB+SEU_IDX_W] == '0)
		else $error("SEU status read wrong");

	wb_write_c:    cover property (cfg_wr_i && cfg_addr_i == IDX_WB_CTRL ##1 vback_en_o);
	roll_valid_c:  cover property (attempt_start_i && st_q.now.record_valid);
	seu_err_c:     cover property (seu_single_err_i ##1 cfg_rd_i && cfg_addr_i == IDX_SEU_STAT);
	four_byte_c:   cover property (four_byte_mode_i && flash_start_o[SWHR_DW-1:FLASH_LOW_W] != '0);
	hist_roll_c:   cover property (attempt_start_i ##1 cfg_rd_i && cfg_addr_i == IDX_HISTORY);

endmodule // swhr_regs

// *** testbench/swhr_regs_test.sv ***
// Purpose: self-checking bench for the SEU, warmboot and boot history bank
// Assumes: inputs change at the falling edge; reads answer one cycle later
// Notes:   table rows cover register access; history and resets follow by hand
`timescale 1ns/1ns
module swhr_regs_test
	import swhr_pkg::*;
;
	logic                 sys_clk_i;
	logic                 rst_b_i;
	logic                 cfg_wr_i;
	logic                 cfg_rd_i;
	logic [SWHR_AW-1:0]   cfg_addr_i;
	logic [SWHR_DW-1:0]   cfg_wdata_i;
	logic [SWHR_DW-1:0]   cfg_rdata_o;
	logic                 cfg_rvalid_o;
	swhr_frame_type       seu_cur_i;
	swhr_frame_type       seu_next_i;
	logic                 seu_single_err_i;
	logic [SEU_IDX_W-1:0] seu_bit_index_i;
	logic                 attempt_start_i;
	swhr_attempt_type     attempt_event_i;
	logic                 four_byte_mode_i;
	logic                 vback_en_o;
	logic [SWHR_DW-1:0]   flash_start_o;
	int                   failures;
	int                   tests_run;
	logic [31:0]          q;
	logic                 row_wr [6];
	logic [4:0]           row_a  [6];
	logic [31:0]          row_d  [6];
	logic [31:0]          row_e  [6];

	swhr_regs u_swhr_regs (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid_o), .seu_cur_i(seu_cur_i), .seu_next_i(seu_next_i),
		.seu_single_err_i(seu_single_err_i), .seu_bit_index_i(seu_bit_index_i),
		.attempt_start_i(attempt_start_i), .attempt_event_i(attempt_event_i),
		.four_byte_mode_i(four_byte_mode_i), .vback_en_o(vback_en_o),
		.flash_start_o(flash_start_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step();
		@(negedge sys_clk_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		step();
		cfg_wr_i = 1'b0;
	endtask

	// Answer stands only in the cycle after the read edge
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		cfg_rd_i = 1'b1;
		cfg_addr_i = a;
		step();
		d = cfg_rdata_o;
		check("rvalid", {31'h0, cfg_rvalid_o}, 32'h1);
		cfg_rd_i = 1'b0;
		// Idle cycle so a following read raises the strobe only once
		step();
	endtask

	task automatic pulse_event(input logic st, input swhr_attempt_type ev);
		attempt_start_i = st;
		attempt_event_i = ev;
		step();
		attempt_start_i = 1'b0;
		attempt_event_i = ATTEMPT_CLR;
	endtask

	task automatic do_reset();
		rst_b_i = 1'b0;
		repeat (5) step();
		check("vback reset", {31'h0, vback_en_o}, 32'h0);
		rst_b_i = 1'b1;
		repeat (3) step();
		rd(IDX_WB_CTRL, q);
		check("ctrl reset", q, 32'h0);
		rd(IDX_WB_FLASH, q);
		check("flash reset", q, 32'h0);
		check("rdata idle", cfg_rdata_o, 32'h0);
		check("rvalid idle", {31'h0, cfg_rvalid_o}, 32'h0);
	endtask

	initial begin
		failures = 0;
		tests_run = 0;
		rst_b_i = 1'b0;
		cfg_wr_i = 1'b0;
		cfg_rd_i = 1'b0;
		cfg_addr_i = 5'h00;
		cfg_wdata_i = 32'h0;
		seu_cur_i = {5'h15, 8'hc3, 8'h7e};
		seu_next_i = {5'h0a, 8'h3c, 8'h81};
		seu_single_err_i = 1'b0;
		seu_bit_index_i = 12'h000;
		attempt_start_i = 1'b0;
		attempt_event_i = ATTEMPT_CLR;
		four_byte_mode_i = 1'b0;
		row_wr = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		row_a  = '{IDX_WB_CTRL, IDX_WB_CTRL, IDX_WB_FLASH, IDX_SEU_CUR, IDX_SEU_NEXT, 5'h05};
		row_d  = '{32'hffff_ffff, 32'h0, 32'ha512_3456, 32'hffff_ffff, 32'h0, 32'h0};
		row_e  = '{32'h1, 32'h0, 32'ha512_3456, 32'h0015_c37e, 32'h000a_3c81, 32'h0};
		step();
		do_reset();
		for (int i = 0; i < 6; i++) begin
			if (row_wr[i]) begin
				wr(row_a[i], row_d[i]);
			end
			rd(row_a[i], q);
			check("table read", q, row_e[i]);
		end
		// Top byte reaches the loader only in four-byte mode
		check("flash 3 byte", flash_start_o, 32'h0012_3456);
		four_byte_mode_i = 1'b1;
		step();
		check("flash 4 byte", flash_start_o, 32'ha512_3456);
		wr(IDX_WB_CTRL, 32'h1);
		check("vback out", {31'h0, vback_en_o}, 32'h1);
		seu_bit_index_i = 12'h9ab;
		seu_single_err_i = 1'b1;
		step();
		seu_single_err_i = 1'b0;
		rd(IDX_SEU_STAT, q);
		check("seu status", q, 32'h0000_4d5a);
		// Scan position moves; reads follow it
		seu_cur_i = {5'h1f, 8'h00, 8'hff};
		seu_next_i = {5'h00, 8'hff, 8'h00};
		step();
		rd(IDX_SEU_CUR, q);
		check("seu cur moved", q, 32'h001f_00ff);
		rd(IDX_SEU_NEXT, q);
		check("seu next moved", q, 32'h0000_ff00);
		pulse_event(1'b0, 7'b101_0011);
		rd(IDX_HISTORY, q);
		check("history now", q, 32'h0000_0053);
		pulse_event(1'b1, 7'b000_0101);
		rd(IDX_HISTORY, q);
		check("history shift", q, 32'h0000_5305);
		pulse_event(1'b1, ATTEMPT_CLR);
		rd(IDX_HISTORY, q);
		check("history clear", q, 32'h0000_0500);
		pulse_event(1'b0, 7'b011_1000);
		rd(IDX_HISTORY, q);
		check("history errs", q, 32'h0000_0538);
		do_reset();
		check("flash out reset", flash_start_o, 32'h0);
		give_verdict();
	end
endmodule // swhr_regs_test
